// >>> verification/dma_channel_descriptor_and_arm_tb_top.sv
// Self-checking bench for the DMA channel engine
`timescale 1ns/1ps
`default_nettype none
module dma_channel_descriptor_and_arm_tb_top;
  localparam logic [11:0] A_DONE = {2'h0, dma_pkg::IDX_DONE, 2'h0};
  localparam logic [11:0] A_CH1 = {2'h0, dma_pkg::IDX_CH1_LO, 2'h0};
  localparam logic [11:0] A_CH0 = {2'h0, dma_pkg::IDX_CH0_LO, 2'h0};
  localparam logic [11:0] A_ARM = {2'h0, dma_pkg::IDX_ARM, 2'h0};
  localparam logic [11:0] A_REQ = {2'h0, dma_pkg::IDX_REQ, 2'h0};
  localparam logic [1:0] OK = dma_pkg::RESP_OKAY;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [7:0] r; logic [1:0] s;} row_t;
  row_t rows [7] = '{'{A_CH0, 32'h10, 8'h10, OK}, '{A_CH0 + 12'h4, 32'h0, 8'h0, OK},
    '{A_CH1, 32'h20, 8'h20, OK}, '{A_CH1 + 12'h4, 32'h100, 8'h0, OK},
    '{A_ARM, 32'h80, 8'h0, OK}, '{A_DONE, 32'h0, 8'h0, OK},
    '{12'h000, 32'h55, 8'h0, dma_pkg::RESP_SLVERR}};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, cpu_bus_req = 1'b0;
  logic bready = 1'b1, rready = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h1, wait_cycles = 4'h0;
  logic [28:0] periph_trigger_source_sel = 29'h0;
  logic awready, wready, bvalid, arready, rvalid, mem_req, mem_we, mem_wide, mem_ack;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [4:0] irq_req, irq_seen;
  int fail_count = 0, total_checks = 0, acks = 0, deny_bad = 0;
  always #12.5 clock = ~clock;
  dma_channel_descriptor_and_arm u_dut (.clock(clock), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .mem_req(mem_req), .mem_we(mem_we), .mem_wide(mem_wide),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .cpu_bus_req(cpu_bus_req), .periph_trigger_source_sel(periph_trigger_source_sel), .irq_req(irq_req));
  mem_model u_mem (.clock(clock), .rst(rst), .wait_cycles(wait_cycles), .mem_req(mem_req),
    .mem_we(mem_we), .mem_wide(mem_wide), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  always @(posedge clock) begin
    irq_seen <= rst ? 5'h00 : irq_seen | irq_req;
    if (mem_req === 1'b1 && mem_ack === 1'b1) acks <= acks + 1;
    if (cpu_bus_req === 1'b1 && mem_req === 1'b1) deny_bad <= deny_bad + 1;
  end
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask : chk
  task automatic tick(inout int n);
    @(posedge clock);
    n++;
  endtask : tick
  // A wait that runs out ends the run at once rather than hanging
  task automatic tmo(input int n);
    if (n >= 200) begin
      $display("CHECK FAILED wait expected done seen timeout");
      fail_count++;
      close_out();
    end
  endtask : tmo
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] s);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do tick(n); while (!(awready === 1'b1 && wready === 1'b1) && n < 200);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do tick(n); while (bvalid !== 1'b1 && n < 200);
    tmo(n);
    chk("bresp", 32'(s), 32'(bresp));
  endtask : axw
  task automatic axr(input logic [11:0] a, input logic [7:0] r, input logic [1:0] s);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do tick(n); while (arready !== 1'b1 && n < 200);
    arvalid <= 1'b0;
    do tick(n); while (rvalid !== 1'b1 && n < 200);
    tmo(n);
    chk("rdata", {24'h0, r}, rdata);
    chk("rresp", 32'(s), 32'(rresp));
  endtask : axr
  task automatic wait_acks(input int k);
    int n = 0;
    do tick(n); while (acks < k && n < 200);
    tmo(n);
  endtask : wait_acks
  task automatic desc(input logic [7:0] b, input logic [63:0] v);
    for (int i = 0; i < 8; i++) u_mem.mem[b + 8'(i)] = v[63 - 8 * i -: 8];
  endtask : desc
  task automatic mchk(input logic [7:0] x, input logic [7:0] e);
    chk("mem", 32'(e), 32'(u_mem.mem[x]));
  endtask : mchk
  initial begin
    int n = 0;
    for (int i = 0; i < 256; i++) u_mem.mem[i] = 8'(i) ^ 8'hA5;
    desc(8'h10, 64'h0040_0080_0003_205A);
    desc(8'h20, 64'h0050_00A0_2005_2070);
    desc(8'h28, 64'h0);
    u_mem.mem[8'h50] = 8'h01;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[i]) begin
      axr(rows[i].a, 8'h00, rows[i].s);
      axw(rows[i].a, rows[i].d, rows[i].s);
      axr(rows[i].a, rows[i].r, rows[i].s);
    end
    axw(A_ARM, 32'h01, OK);
    wait_acks(8);
    axw(A_REQ, 32'h01, OK);
    wait_acks(14);
    repeat (4) tick(n);
    for (int i = 0; i < 4; i++) mchk(8'h80 + 8'(i), 8'(i < 3 ? 8'h40 + i : 8'h80 + i) ^ 8'hA5);
    chk("irq0", 32'h1, 32'(irq_seen[0]));
    axr(A_ARM, 8'h00, OK);
    axr(A_REQ, 8'h00, OK);
    wait_cycles <= 4'h3;
    cpu_bus_req <= 1'b1;
    axw(A_ARM, 32'h02, OK);
    repeat (20) tick(n);
    chk("denied", 32'h0, 32'(deny_bad));
    cpu_bus_req <= 1'b0;
    wait_acks(22);
    axw(A_REQ, 32'h02, OK);
    wait_acks(26);
    repeat (4) tick(n);
    mchk(8'hA0, 8'h01);
    mchk(8'h9F, 8'h51 ^ 8'hA5);
    mchk(8'h9E, 8'h9E ^ 8'hA5);
    chk("irq1", 32'h0, 32'(irq_seen[1]));
    axr(A_DONE, 8'h03, OK);
    axw(A_ARM, 32'h04, OK);
    axw(A_ARM, 32'h84, OK);
    axr(A_ARM, 8'h00, OK);
    axw(A_REQ, 32'h04, OK);
    repeat (40) tick(n);
    axr(A_DONE, 8'h03, OK);
    close_out();
  end
endmodule : dma_channel_descriptor_and_arm_tb_top
`default_nettype wire

// >>> verification/mem_model.sv
// Behavioural memory standing on the far side of the engine's bus
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] wait_cycles,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_wide,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [0:255];
  logic [3:0] cnt;
  wire logic [7:0] lo = mem_addr[7:0];
  wire logic [15:0] word = {mem[lo + 8'h01], mem[lo]};
  // Outside an ack the bus shows the inverse, so a stale sample never matches
  assign mem_rdata = mem_ack ? word : ~word;
  always @(posedge clock) begin
    mem_ack <= 1'b0;
    if (mem_req && mem_ack && mem_we) begin
      mem[lo] <= mem_wdata[7:0];
      if (mem_wide) begin
        mem[lo + 8'h01] <= mem_wdata[15:8];
      end
    end
    if (rst || !mem_req || mem_ack) begin
      cnt <= 4'h0;
    end else if (cnt >= wait_cycles) begin
      mem_ack <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : mem_model
`default_nettype wire

// >>> verilog/dma_channel_descriptor_and_arm.sv
// Five-channel DMA engine with descriptor fetch, arming and bus arbitration
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Length mode 111 uses the fixed count; 101 and 110 are reserved.
// - Thirteen-bit fixed count from bytes 4 and 5 caps variable lengths.
// - Counts are in words when wide transfers are selected, else bytes.
// - Byte 6 bit 7 picks 8-bit or 16-bit transfers.
// - Byte 6 bits 6:5 pick single, block, repeated single or repeated block.
// - Trigger code 00000 means only the software request starts the channel.
// - Trigger code 00001 means completion of the previous channel.
// - Codes 00010 to 11110 select peripheral events in ascending order.
// - Source address steps by 0, +1, +2 or -1 units per transfer.
// - Destination address steps the same way from byte 7 bits 5:4.
// - Byte 7 bit 3 gates the completion interrupt request.
// - For byte transfers, byte 7 bit 2 keeps only 7 length bits.
// - Priority 00 yields to CPU, 01 wins every second try, 10 wins.
// - Arm write with bit 7 set aborts every channel written as 1.
// - No transfer starts on a channel whose arm bit is clear.
// - Single and block modes clear the arm bit on completion.
// - Modes 001 to 100 take first unit plus 1, 0, 2, 3, capped.
// - Completion sets the channel's done flag.
// - Software request acts as one trigger, cleared when the loaded channel is granted.
// - Channel 0 has its own descriptor pointer; 1 to 4 share one.
module dma_channel_descriptor_and_arm (
  input wire logic clock,
  input wire logic rst,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic mem_req,
  output logic mem_we,
  output logic mem_wide,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic cpu_bus_req,
  input wire logic [28:0] periph_trigger_source_sel,
  output logic [4:0] irq_req
);
  localparam int N = dma_pkg::NCH;

  function automatic logic reg_known(input logic [9:0] a);
    reg_known = (a[9:8] == 2'h0) && (a[7:0] >= dma_pkg::IDX_DONE) &&
                (a[7:0] <= dma_pkg::IDX_REQ);
  endfunction : reg_known

  function automatic logic [2:0] lowest(input logic [4:0] v);
    lowest = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) lowest = 3'(i);
    end
  endfunction : lowest

  dma_pkg::state_t state, next_state;
  logic [6:0] arm;
  logic [4:0] req, pend, loaded, first_pend, channel_done_flag;
  logic [15:0] ch0_descriptor_pointer, ch1to4_descriptor_pointer;
  logic [15:0] src_a [N];
  logic [15:0] dst_a [N];
  logic [12:0] left [N];
  logic [31:0] desc_mem [N];
  logic [2:0] cur, idx;
  logic [15:0] xfer_data;
  logic lost_turn;

  // Register bus decode
  logic wr_fire, wr_en, arm_wr, req_wr, done_wr, rd_fire;
  logic [7:0] wr_idx;
  logic [4:0] abort_hit, need, trigger_source_sel_hit, done_pulse, auto_clr, next_arm_lo, next_done;
  logic [2:0] pick;
  logic grant, service, want_bus, allowed, acked, last_unit, complete, abort_cur;
  logic [15:0] base;
  logic [31:0] rd_word;

  assign wr_fire = awvalid & wvalid & ~bvalid;
  assign awready = wvalid & ~bvalid;
  assign wready = awvalid & ~bvalid;
  assign wr_idx = awaddr[9:2];
  assign wr_en = wr_fire & reg_known(awaddr[11:2]) & wstrb[0];
  assign arm_wr = wr_en & (wr_idx == dma_pkg::IDX_ARM);
  assign req_wr = wr_en & (wr_idx == dma_pkg::IDX_REQ);
  assign done_wr = wr_en & (wr_idx == dma_pkg::IDX_DONE);
  assign rd_fire = arvalid & ~rvalid;
  assign arready = ~rvalid;
  assign abort_hit = (arm_wr & wdata[dma_pkg::ABORT_BIT]) ? wdata[4:0] : 5'h00;

  // Current channel descriptor fields
  logic [31:0] cur_desc;
  logic [2:0] length_mode_sel;
  logic [12:0] fixed_transfer_count, var_total;
  logic wide_transfer_sel, done_irq_gate, is_variable;
  logic [1:0] transfer_kind_sel, source_step_sel, dest_step_sel, priority_sel;

  assign cur_desc = desc_mem[cur];

  dma_descriptor_decode dec (
    .desc(cur_desc),
    .first_data(xfer_data),
    .length_mode_sel(length_mode_sel),
    .fixed_transfer_count(fixed_transfer_count),
    .wide_transfer_sel(wide_transfer_sel),
    .transfer_kind_sel(transfer_kind_sel),
    .trigger_source_sel(),
    .source_step_sel(source_step_sel),
    .dest_step_sel(dest_step_sel),
    .done_irq_gate(done_irq_gate),
    .length_byte_7bit_sel(),
    .priority_sel(priority_sel),
    .is_variable(is_variable),
    .var_total(var_total)
  );

  // Arming: an unloaded armed channel fetches its descriptor first
  assign need = arm[4:0] & (~loaded | pend | req);
  assign pick = lowest(need);
  assign grant = (state == dma_pkg::S_IDLE) & (|need) & ~abort_hit[pick];
  assign service = grant & loaded[pick];
  assign abort_cur = (state != dma_pkg::S_IDLE) & abort_hit[cur];

  assign base = (cur == 3'h0) ? ch0_descriptor_pointer :
                ch1to4_descriptor_pointer + {10'h000, 3'(cur - 3'h1), 3'h0};
  assign want_bus = (state != dma_pkg::S_IDLE);
  // Priority 11 is treated as 10; it is kept for port access by software
  assign allowed = priority_sel[1] | ~cpu_bus_req |
                   ((priority_sel == dma_pkg::PRIO_GUAR) & lost_turn);
  assign mem_req = want_bus & allowed;
  assign mem_we = (state == dma_pkg::S_WRITE);
  assign mem_wide = wide_transfer_sel & (state != dma_pkg::S_FETCH);
  assign mem_addr = (state == dma_pkg::S_FETCH) ? base + {13'h0000, idx} :
                    (state == dma_pkg::S_READ) ? src_a[cur] : dst_a[cur];
  assign mem_wdata = xfer_data;
  assign acked = mem_req & mem_ack;
  // One count step per unit, whether byte or word
  assign last_unit = first_pend[cur] ? (var_total <= 13'h0001) :
                     (left[cur] <= 13'h0001);
  assign complete = (state == dma_pkg::S_WRITE) & acked & last_unit & ~abort_hit[cur];

  always_comb begin
    done_pulse = 5'h00;
    done_pulse[cur] = complete;
  end

  // Hardware triggers are only looked at once the descriptor is known
  always_comb begin
    logic [4:0] sel;
    sel = 5'h00;
    for (int i = 0; i < N; i++) begin
      sel = desc_mem[i][dma_pkg::TRIGGER_SOURCE_SEL_HI:dma_pkg::TRIGGER_SOURCE_SEL_LO];
      trigger_source_sel_hit[i] = 1'b0;
      if (!loaded[i] || sel == dma_pkg::TRIGGER_SOURCE_SEL_NONE) begin
        trigger_source_sel_hit[i] = 1'b0;
      end else if (sel == dma_pkg::TRIGGER_SOURCE_SEL_CHAIN) begin
        trigger_source_sel_hit[i] = done_pulse[(i + N - 1) % N];
      end else if (sel <= dma_pkg::TRIGGER_SOURCE_SEL_LAST) begin
        trigger_source_sel_hit[i] = periph_trigger_source_sel[5'(sel - dma_pkg::TRIGGER_SOURCE_SEL_FIRST)];
      end
    end
  end

  assign auto_clr = transfer_kind_sel[1] ? 5'h00 : done_pulse;
  assign next_arm_lo = !arm_wr ? arm[4:0] & ~auto_clr :
                       wdata[dma_pkg::ABORT_BIT] ? arm[4:0] & ~auto_clr & ~wdata[4:0] :
                       wdata[4:0];
  // A completion in the same cycle as a clearing write still leaves its flag
  assign next_done = (channel_done_flag & (done_wr ? wdata[4:0] : 5'h1F)) | done_pulse;

  always_comb begin
    next_state = state;
    case (state)
      dma_pkg::S_IDLE: begin
        if (grant) next_state = loaded[pick] ? dma_pkg::S_READ : dma_pkg::S_FETCH;
      end
      dma_pkg::S_FETCH: begin
        if (acked && idx == dma_pkg::LAST_DESC_BYTE) next_state = dma_pkg::S_IDLE;
      end
      dma_pkg::S_READ: begin
        if (acked) next_state = dma_pkg::S_WRITE;
      end
      dma_pkg::S_WRITE: begin
        if (acked) begin
          next_state = (last_unit || !transfer_kind_sel[0]) ? dma_pkg::S_IDLE :
                       dma_pkg::S_READ;
        end
      end
      default: next_state = dma_pkg::S_IDLE;
    endcase
    if (abort_cur) next_state = dma_pkg::S_IDLE;
  end

  always_comb begin
    case (araddr[9:2])
      dma_pkg::IDX_DONE: rd_word = {27'h0000000, channel_done_flag};
      dma_pkg::IDX_CH1_LO: rd_word = {24'h000000, ch1to4_descriptor_pointer[7:0]};
      dma_pkg::IDX_CH1_HI: rd_word = {24'h000000, ch1to4_descriptor_pointer[15:8]};
      dma_pkg::IDX_CH0_LO: rd_word = {24'h000000, ch0_descriptor_pointer[7:0]};
      dma_pkg::IDX_CH0_HI: rd_word = {24'h000000, ch0_descriptor_pointer[15:8]};
      dma_pkg::IDX_ARM: rd_word = {24'h000000, 1'b0, arm};
      dma_pkg::IDX_REQ: rd_word = {27'h0000000, req};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Bus slave answers
  always_ff @(posedge clock) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= dma_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= dma_pkg::RESP_OKAY;
      rdata <= 32'h00000000;
    end else begin
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= reg_known(awaddr[11:2]) ? dma_pkg::RESP_OKAY : dma_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata <= reg_known(araddr[11:2]) ? rd_word : 32'h00000000;
        rresp <= reg_known(araddr[11:2]) ? dma_pkg::RESP_OKAY : dma_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      arm <= dma_pkg::ARM_RESET[6:0];
      channel_done_flag <= 5'h00;
      ch0_descriptor_pointer <= dma_pkg::PTR_RESET;
      ch1to4_descriptor_pointer <= dma_pkg::PTR_RESET;
      irq_req <= 5'h00;
    end else begin
      arm[4:0] <= next_arm_lo;
      if (arm_wr && !wdata[dma_pkg::ABORT_BIT]) arm[6:5] <= wdata[6:5];
      channel_done_flag <= next_done;
      irq_req <= done_pulse & {5{done_irq_gate}};
      if (wr_en && wr_idx == dma_pkg::IDX_CH0_LO) ch0_descriptor_pointer[7:0] <= wdata[7:0];
      if (wr_en && wr_idx == dma_pkg::IDX_CH0_HI) ch0_descriptor_pointer[15:8] <= wdata[7:0];
      if (wr_en && wr_idx == dma_pkg::IDX_CH1_LO) ch1to4_descriptor_pointer[7:0] <= wdata[7:0];
      if (wr_en && wr_idx == dma_pkg::IDX_CH1_HI) ch1to4_descriptor_pointer[15:8] <= wdata[7:0];
    end
  end

  // Per-channel trigger latches; a new event wins over the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      req <= 5'h00;
      pend <= 5'h00;
      loaded <= 5'h00;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (req_wr && wdata[i]) req[i] <= 1'b1;
        else if ((service && pick == 3'(i)) || abort_hit[i]) req[i] <= 1'b0;
        if (trigger_source_sel_hit[i]) pend[i] <= 1'b1;
        else if ((service && pick == 3'(i)) || abort_hit[i] || !loaded[i]) pend[i] <= 1'b0;
        if (abort_hit[i] || done_pulse[i]) loaded[i] <= 1'b0;
        else if (state == dma_pkg::S_FETCH && acked && idx == dma_pkg::LAST_DESC_BYTE &&
                 cur == 3'(i)) loaded[i] <= 1'b1;
      end
    end
  end

  // Engine state and per-channel transfer progress
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= dma_pkg::S_IDLE;
      cur <= 3'h0;
      idx <= 3'h0;
      xfer_data <= 16'h0000;
      lost_turn <= 1'b0;
      first_pend <= 5'h00;
      // Cleared so a first fetch arbitrates at low priority, never on unknown bits
      for (int i = 0; i < N; i++) desc_mem[i] <= 32'h00000000;
    end else begin
      state <= next_state;
      if (acked) lost_turn <= 1'b0;
      else if (want_bus && !mem_req) lost_turn <= 1'b1;
      if (grant) begin
        cur <= pick;
        idx <= 3'h0;
      end
      if (state == dma_pkg::S_FETCH && acked) begin
        idx <= idx + 3'h1;
        case (idx)
          3'h0: src_a[cur][15:8] <= mem_rdata[7:0];
          3'h1: src_a[cur][7:0] <= mem_rdata[7:0];
          3'h2: dst_a[cur][15:8] <= mem_rdata[7:0];
          3'h3: dst_a[cur][7:0] <= mem_rdata[7:0];
          3'h4: desc_mem[cur][31:24] <= mem_rdata[7:0];
          3'h5: desc_mem[cur][23:16] <= mem_rdata[7:0];
          3'h6: desc_mem[cur][15:8] <= mem_rdata[7:0];
          default: begin
            desc_mem[cur][7:0] <= mem_rdata[7:0];
            left[cur] <= fixed_transfer_count;
            first_pend[cur] <= is_variable;
          end
        endcase
      end
      if (state == dma_pkg::S_READ && acked) xfer_data <= mem_rdata;
      if (state == dma_pkg::S_WRITE && acked) begin
        src_a[cur] <= dma_pkg::addr_step(src_a[cur], source_step_sel, wide_transfer_sel);
        dst_a[cur] <= dma_pkg::addr_step(dst_a[cur], dest_step_sel, wide_transfer_sel);
        left[cur] <= first_pend[cur] ? var_total - 13'h0001 : left[cur] - 13'h0001;
        first_pend[cur] <= 1'b0;
      end
    end
  end

  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_lose_guar;
    want_bus && !mem_req && priority_sel == dma_pkg::PRIO_GUAR;
  endsequence
  sequence s_single_done;
    complete && !transfer_kind_sel[1] && !arm_wr;
  endsequence

  a_abort_disarms: assert property (abort_hit != 5'h00 |=> (arm[4:0] & $past(abort_hit)) == 5'h00)
    else $error("abort left a channel armed");
  a_armed_transfer: assert property ((state == dma_pkg::S_READ && acked) |-> arm[cur])
    else $error("transfer on unarmed channel");
  a_single_disarm: assert property (s_single_done |=> !arm[$past(cur)])
    else $error("single mode kept arm bit");
  a_done_flag_set: assert property (complete |=> channel_done_flag[$past(cur)])
    else $error("done flag not set");
  a_req_cleared: assert property ((service && !req_wr) |=> !req[$past(pick)])
    else $error("request not cleared on grant");
  a_cpu_wins_low: assert property ((mem_req && priority_sel == dma_pkg::PRIO_LOW) |-> !cpu_bus_req)
    else $error("low priority took bus from CPU");
  a_guar_turn: assert property (s_lose_guar ##1 want_bus |-> mem_req)
    else $error("guaranteed channel lost twice");
  a_high_wins: assert property ((want_bus && priority_sel[1]) |-> mem_req)
    else $error("high priority channel held off");
  a_irq_gated: assert property ((irq_req != 5'h00) |-> $past(complete) && $past(done_irq_gate))
    else $error("irq without gated completion");
  a_lowest_first: assert property (grant |-> (need & ((5'h01 << pick) - 5'h01)) == 5'h00)
    else $error("lower channel skipped");
  a_abort_reads_zero: assert property (rd_fire |=> !rdata[dma_pkg::ABORT_BIT])
    else $error("abort bit read back as one");
endmodule : dma_channel_descriptor_and_arm
`default_nettype wire

// >>> verilog/dma_descriptor_decode.sv
// Field decoder for descriptor bytes 4 to 7 and the variable length count
`timescale 1ns/1ps
`default_nettype none
module dma_descriptor_decode (
  input wire logic [31:0] desc,
  input wire logic [15:0] first_data,
  output logic [2:0] length_mode_sel,
  output logic [12:0] fixed_transfer_count,
  output logic wide_transfer_sel,
  output logic [1:0] transfer_kind_sel,
  output logic [4:0] trigger_source_sel,
  output logic [1:0] source_step_sel,
  output logic [1:0] dest_step_sel,
  output logic done_irq_gate,
  output logic length_byte_7bit_sel,
  output logic [1:0] priority_sel,
  output logic is_variable,
  output logic [12:0] var_total
);
  logic [12:0] first_len;
  logic [13:0] raw_total;

  assign length_mode_sel = desc[31:29];
  assign fixed_transfer_count = desc[28:16];
  assign wide_transfer_sel = desc[15];
  assign transfer_kind_sel = desc[14:13];
  assign trigger_source_sel = desc[12:8];
  assign source_step_sel = desc[7:6];
  assign dest_step_sel = desc[5:4];
  assign done_irq_gate = desc[3];
  assign length_byte_7bit_sel = desc[2];
  assign priority_sel = desc[1:0];
  // Reserved codes fall back to the fixed count, so nothing relies on them
  assign is_variable = (length_mode_sel >= dma_pkg::LENGTH_MODE_SEL_PLUS1) &&
                       (length_mode_sel <= dma_pkg::LENGTH_MODE_SEL_PLUS3);
  // The 7-bit option only matters for byte transfers
  assign first_len = wide_transfer_sel ? first_data[12:0] :
                     length_byte_7bit_sel ? {6'h00, first_data[6:0]} :
                     {5'h00, first_data[7:0]};

  always_comb begin
    case (length_mode_sel)
      dma_pkg::LENGTH_MODE_SEL_PLUS1: raw_total = {1'b0, first_len} + 14'h0001;
      dma_pkg::LENGTH_MODE_SEL_PLUS0: raw_total = {1'b0, first_len};
      dma_pkg::LENGTH_MODE_SEL_PLUS2: raw_total = {1'b0, first_len} + 14'h0002;
      dma_pkg::LENGTH_MODE_SEL_PLUS3: raw_total = {1'b0, first_len} + 14'h0003;
      default: raw_total = {1'b0, fixed_transfer_count};
    endcase
  end

  // The fixed count caps every variable length
  assign var_total = (raw_total > {1'b0, fixed_transfer_count}) ?
                     fixed_transfer_count : raw_total[12:0];
endmodule : dma_descriptor_decode
`default_nettype wire

// >>> verilog/dma_pkg.sv
// Shared constants, types and helpers for the DMA channel block
`default_nettype none
package dma_pkg;
  localparam int NCH = 5;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DONE = 8'hD1;
  localparam logic [7:0] IDX_CH1_LO = 8'hD2;
  localparam logic [7:0] IDX_CH1_HI = 8'hD3;
  localparam logic [7:0] IDX_CH0_LO = 8'hD4;
  localparam logic [7:0] IDX_CH0_HI = 8'hD5;
  localparam logic [7:0] IDX_ARM = 8'hD6;
  localparam logic [7:0] IDX_REQ = 8'hD7;
  localparam int ABORT_BIT = 7;
  localparam logic [7:0] ARM_RESET = 8'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Length modes
  localparam logic [2:0] LENGTH_MODE_SEL_FIXED = 3'h0;
  localparam logic [2:0] LENGTH_MODE_SEL_PLUS1 = 3'h1;
  localparam logic [2:0] LENGTH_MODE_SEL_PLUS0 = 3'h2;
  localparam logic [2:0] LENGTH_MODE_SEL_PLUS2 = 3'h3;
  localparam logic [2:0] LENGTH_MODE_SEL_PLUS3 = 3'h4;
  localparam logic [2:0] LENGTH_MODE_SEL_FIXED_ALT = 3'h7;
  // Transfer kinds; bit 0 set means block, bit 1 set means repeated
  localparam logic [1:0] KIND_SINGLE = 2'h0;
  localparam logic [1:0] KIND_BLOCK = 2'h1;
  localparam logic [1:0] KIND_RSINGLE = 2'h2;
  localparam logic [1:0] KIND_RBLOCK = 2'h3;
  localparam logic [4:0] TRIGGER_SOURCE_SEL_NONE = 5'h00;
  localparam logic [4:0] TRIGGER_SOURCE_SEL_CHAIN = 5'h01;
  localparam logic [4:0] TRIGGER_SOURCE_SEL_FIRST = 5'h02;
  localparam logic [4:0] TRIGGER_SOURCE_SEL_LAST = 5'h1E;
  localparam int TRIGGER_SOURCE_SEL_LO = 8;
  localparam int TRIGGER_SOURCE_SEL_HI = 12;
  localparam logic [1:0] STEP_NONE = 2'h0;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] STEP_TWO = 2'h2;
  localparam logic [1:0] PRIO_LOW = 2'h0;
  localparam logic [1:0] PRIO_GUAR = 2'h1;
  localparam logic [1:0] PRIO_HIGH = 2'h2;
  localparam logic [2:0] LAST_DESC_BYTE = 3'h7;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_FETCH = 4'h2,
    S_READ = 4'h4,
    S_WRITE = 4'h8
  } state_t;

  // Address update after one transfer; a unit is a byte or a word
  function automatic logic [15:0] addr_step(input logic [15:0] a, input logic [1:0] s,
                                            input logic w);
    logic [15:0] u;
    u = w ? 16'h0002 : 16'h0001;
    case (s)
      STEP_NONE: addr_step = a;
      STEP_ONE: addr_step = a + u;
      STEP_TWO: addr_step = a + (u << 1);
      default: addr_step = a - u;
    endcase
  endfunction : addr_step
endpackage : dma_pkg
`default_nettype wire
